// >>> aux_counter_pkg.sv
package aux_counter_pkg;

  // ==========================================================
  // register map (byte addresses, one aligned word each)
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h04;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_ENABLES = 8'h10;

  // ==========================================================
  // control register fields, and the overflow bit of the flags and enables registers
  localparam int BIT_ON = 0;
  localparam int BIT_CLK_SRC = 1;
  localparam int BIT_SYNC_N = 2;
  localparam int BIT_SEL_LO = 3;
  localparam int BIT_PRESC_LO = 4;
  localparam int BIT_PRESC_HI = 5;
  localparam int BIT_SEL_HI = 6;
  localparam int BIT_WIDE = 7;
  localparam int BIT_OVF = 1;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // ==========================================================
  // timing and codes
  localparam logic [1:0] INSTR_LAST_PHASE = 2'h3;
  localparam logic [3:0] SPECIAL_EVENT_MODE = 4'hb;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic reg_mapped(input logic [7:0] addr);
    reg_mapped = (addr == ADDR_CONTROL) || (addr == ADDR_COUNT_LOW) ||
                 (addr == ADDR_COUNT_HIGH) || (addr == ADDR_FLAGS) ||
                 (addr == ADDR_ENABLES);
  endfunction

  // terminal prescaler value for codes 1:1, 1:2, 1:4, 1:8
  function automatic logic [2:0] presc_last(input logic [1:0] code);
    case (code)
      2'h0: presc_last = 3'h0;
      2'h1: presc_last = 3'h1;
      2'h2: presc_last = 3'h3;
      default: presc_last = 3'h7;
    endcase
  endfunction

endpackage

// >>> reg_access_if.sv
`timescale 1ns/1ns
`default_nettype none
interface reg_access_if;
  logic wr_en;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic rd_en;
  logic [7:0] raddr;
  logic [7:0] rdata;
  modport bus (output wr_en, output waddr, output wdata, output rd_en, output raddr,
    input rdata);
  modport regs (input wr_en, input waddr, input wdata, input rd_en, input raddr,
    output rdata);
endinterface
`default_nettype wire

// >>> axil_slave.sv
`timescale 1ns/1ns
`default_nettype none
module axil_slave
  import aux_counter_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  reg_access_if.bus acc
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } slave_state_s;

  slave_state_s st;
  slave_state_s next_st;
  logic wfire;
  logic rfire;

  // ==========================================================
  // handshakes
  always_comb
  begin
    next_st = st;
    wfire = st.aw_held && st.w_held && !st.bvalid;
    rfire = s_axi_arvalid && st.arready;
    acc.wr_en = wfire && st.wstrb0 && reg_mapped(st.awaddr);
    acc.waddr = st.awaddr;
    acc.wdata = st.wdata;
    acc.rd_en = rfire && reg_mapped(s_axi_araddr);
    acc.raddr = s_axi_araddr;
    if (s_axi_awvalid && st.awready)
    begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready)
    begin
      next_st.w_held = 1'b1;
      next_st.wdata = s_axi_wdata[7:0];
      next_st.wstrb0 = s_axi_wstrb[0];
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    if (wfire)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = reg_mapped(st.awaddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    if (rfire)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = reg_mapped(s_axi_araddr) ? acc.rdata : 8'h00;
      next_st.rresp = reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    // one write and one read in flight; ready stays low until answered
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready = !next_st.w_held && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = {24'h000000, st.rdata};

endmodule
`default_nettype wire

// >>> aux_counter.sv
`timescale 1ns/1ns
`default_nettype none
module aux_counter
  import aux_counter_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [aux_counter_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [aux_counter_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_count_clock_pin,
  input wire logic lp_osc_in_pin,
  input wire logic lp_osc_enable,
  input wire logic [1:0] port_c_direction,
  input wire logic [3:0] unit_one_mode,
  input wire logic unit_one_match,
  input wire logic [3:0] unit_two_mode,
  input wire logic unit_two_match,
  output logic overflow_irq,
  output logic unit_one_uses_this,
  output logic unit_two_uses_this,
  output logic [1:0] port_c_direction_eff,
  output logic [1:0] port_c_pin_read
);
  import aux_counter_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] count;
    logic [7:0] high_buffer;
    logic [2:0] presc;
    logic [1:0] phase;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic ext_prev;
    logic seen_fall;
    logic edge_pending;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic irq;
    logic unit_one_this;
    logic unit_two_this;
    logic [1:0] dir_eff;
    logic [1:0] pin_read;
  } counter_state_s;

  counter_state_s st;
  counter_state_s next_st;

  reg_access_if acc ();

  axil_slave u_axil_slave (
    .mclk(mclk),
    .arst_n(arst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .acc(acc)
  );

  // ==========================================================
  // decoded control fields
  logic counter_on;
  logic clock_source_select;
  logic ext_clock_sync_n;
  logic [1:0] prescale_sel;
  logic [1:0] timebase_sel;
  logic wide_access_enable;

  assign counter_on = st.ctrl[BIT_ON];
  assign clock_source_select = st.ctrl[BIT_CLK_SRC];
  assign ext_clock_sync_n = st.ctrl[BIT_SYNC_N];
  assign prescale_sel = {st.ctrl[BIT_PRESC_HI], st.ctrl[BIT_PRESC_LO]};
  assign timebase_sel = {st.ctrl[BIT_SEL_HI], st.ctrl[BIT_SEL_LO]};
  assign wide_access_enable = st.ctrl[BIT_WIDE];

  // ==========================================================
  // clock source and edge detection
  logic instr_tick;
  logic ext_level;
  logic ext_rise;
  logic ext_fall;
  logic ext_edge;
  logic src_tick;
  logic presc_tick;
  logic unit_one_this_now;
  logic unit_two_this_now;
  logic special_clear;
  logic wr_low;
  logic wr_high;

  always_comb
  begin
    instr_tick = (st.phase == INSTR_LAST_PHASE);
    // oscillator pin replaces the plain clock pin when the oscillator runs
    ext_level = lp_osc_enable ? st.pin_s2[1] : st.pin_s2[0];
    ext_rise = ext_level && !st.ext_prev;
    ext_fall = !ext_level && st.ext_prev;
    ext_edge = ext_rise && st.seen_fall;
    if (!clock_source_select)
      src_tick = instr_tick;
    else if (ext_clock_sync_n)
      src_tick = ext_edge;
    else
      src_tick = (ext_edge || st.edge_pending) && instr_tick;
    src_tick = src_tick && counter_on;
    presc_tick = src_tick && (st.presc == presc_last(prescale_sel));
    unit_one_this_now = timebase_sel[1];
    unit_two_this_now = timebase_sel != 2'h0;
    special_clear = (unit_one_this_now && unit_one_mode == SPECIAL_EVENT_MODE &&
                     unit_one_match) ||
                    (unit_two_this_now && unit_two_mode == SPECIAL_EVENT_MODE &&
                     unit_two_match);
    wr_low = acc.wr_en && acc.waddr == ADDR_COUNT_LOW;
    wr_high = acc.wr_en && acc.waddr == ADDR_COUNT_HIGH;
  end

  // ==========================================================
  // register read path
  always_comb
  begin
    if (acc.raddr == ADDR_CONTROL)
      acc.rdata = st.ctrl;
    else if (acc.raddr == ADDR_COUNT_LOW)
      acc.rdata = st.count[7:0];
    else if (acc.raddr == ADDR_COUNT_HIGH)
      acc.rdata = wide_access_enable ? st.high_buffer : st.count[15:8];
    else if (acc.raddr == ADDR_FLAGS)
      acc.rdata = {6'h00, st.overflow_flag, 1'b0};
    else if (acc.raddr == ADDR_ENABLES)
      acc.rdata = {6'h00, st.overflow_irq_enable, 1'b0};
    else
      acc.rdata = 8'h00;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_st = st;
    next_st.pin_s1 = {lp_osc_in_pin, ext_count_clock_pin};
    next_st.pin_s2 = st.pin_s1;
    next_st.ext_prev = ext_level;
    next_st.phase = st.phase + 2'h1;

    // edge arming drops whenever the external path is idle
    if (!(clock_source_select && counter_on))
      next_st.seen_fall = 1'b0;
    else if (ext_fall)
      next_st.seen_fall = 1'b1;

    // synchronised mode holds an edge until the instruction boundary
    if (instr_tick || !clock_source_select || ext_clock_sync_n || !counter_on)
      next_st.edge_pending = 1'b0;
    else if (ext_edge)
      next_st.edge_pending = 1'b1;

    // prescaler
    if (wr_low)
      next_st.presc = 3'h0;
    else if (presc_tick)
      next_st.presc = 3'h0;
    else if (src_tick)
      next_st.presc = st.presc + 3'h1;

    // counter: software write first, then special clear, then increment
    if (wr_low)
    begin
      if (wide_access_enable)
        next_st.count = {st.high_buffer, acc.wdata};
      else
        next_st.count[7:0] = acc.wdata;
    end
    else if (wr_high && !wide_access_enable)
      next_st.count[15:8] = acc.wdata;
    else if (special_clear)
      next_st.count = 16'h0000;
    else if (presc_tick)
      next_st.count = st.count + 16'h0001;

    if (wr_high && wide_access_enable)
      next_st.high_buffer = acc.wdata;
    else if (acc.rd_en && acc.raddr == ADDR_COUNT_LOW && wide_access_enable)
      next_st.high_buffer = st.count[15:8];

    // control and enable registers
    if (acc.wr_en && acc.waddr == ADDR_CONTROL)
      next_st.ctrl = acc.wdata;
    if (acc.wr_en && acc.waddr == ADDR_ENABLES)
      next_st.overflow_irq_enable = acc.wdata[BIT_OVF];

    // software may write the flag either way; a wrap in the same cycle wins
    if (acc.wr_en && acc.waddr == ADDR_FLAGS)
      next_st.overflow_flag = acc.wdata[BIT_OVF];
    if (presc_tick && st.count == COUNT_MAX && !wr_low && !wr_high && !special_clear)
      next_st.overflow_flag = 1'b1;

    next_st.irq = next_st.overflow_flag && next_st.overflow_irq_enable;
    next_st.unit_one_this = unit_one_this_now;
    next_st.unit_two_this = unit_two_this_now;

    // oscillator pins turn into inputs and read as zero
    if (lp_osc_enable)
    begin
      next_st.dir_eff = 2'h3;
      next_st.pin_read = 2'h0;
    end
    else
    begin
      next_st.dir_eff = port_c_direction;
      next_st.pin_read = st.pin_s2;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      st.ctrl <= CONTROL_RESET;
    end
    else
      st <= next_st;
  end

  assign overflow_irq = st.irq;
  assign unit_one_uses_this = st.unit_one_this;
  assign unit_two_uses_this = st.unit_two_this;
  assign port_c_direction_eff = st.dir_eff;
  assign port_c_pin_read = st.pin_read;

endmodule
`default_nettype wire

// >>> aux_counter_sva.sv
`timescale 1ns/1ns
`default_nettype none
module aux_counter_sva
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic lp_osc_enable,
  input wire logic [1:0] port_c_direction,
  input wire logic [1:0] port_c_direction_eff,
  input wire logic [1:0] port_c_pin_read
);
  // ==========
  // port relations
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    ##[1:2] s_axi_bvalid;
  endsequence
  property p_osc_dir;
    lp_osc_enable |=> port_c_direction_eff == 2'h3;
  endproperty
  a_osc_dir: assert property (p_osc_dir) else $error("pins not forced to input");
  property p_osc_read;
    lp_osc_enable |=> port_c_pin_read == 2'h0;
  endproperty
  a_osc_read: assert property (p_osc_read) else $error("osc pins not read as zero");
  property p_dir_pass;
    // no attempt from the release edge: the register still holds its reset zero there
    arst_n && !lp_osc_enable |=> port_c_direction_eff == $past(port_c_direction);
  endproperty
  a_dir_pass: assert property (p_dir_pass) else $error("direction bits not passed");
  property p_wr_answer;
    s_wr_taken |-> s_wr_answer;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  property p_unmapped;
    s_wr_taken ##0 (s_axi_awaddr > 8'h10 || s_axi_awaddr[1:0] != 2'h0)
      |-> s_wr_answer ##0 s_axi_bresp == 2'h2;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write not refused");
  property p_wr_block;
    s_wr_taken |=> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("second write accepted early");
  property p_b_end;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_end: assert property (p_b_end) else $error("write response repeated");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read data late");
  property p_r_end;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_end: assert property (p_r_end) else $error("read response repeated");
  property p_rd_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_arready;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read word malformed");
endmodule
bind aux_counter aux_counter_sva u_aux_counter_sva (.mclk, .arst_n, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .lp_osc_enable, .port_c_direction,
  .port_c_direction_eff, .port_c_pin_read);
`default_nettype wire

// >>> ext_clock_src.sv
`timescale 1ns/1ns
`default_nettype none
module ext_clock_src
(
  output var logic pin
);
  // ==========
  // gated source: stands low between bursts
  initial pin = 1'h0;
  // odd delays keep rising edges away from mclk edges; falls come 400 ns apart, on mclk rising edges
  task automatic burst(input int n);
    repeat (n)
    begin
      #213 pin = 1'h1;
      #187 pin = 1'h0;
    end
  endtask
endmodule
`default_nettype wire

// >>> test_aux_counter.sv
`timescale 1ns/1ns
`default_nettype none
module test_aux_counter;
  import aux_counter_pkg::*;
  typedef struct packed {logic [7:0] ctl; logic [1:0] uses;} row_s;
  logic mclk = 1'h0;
  logic arst_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rd;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, lp_osc_enable = 1'h0;
  logic unit_one_match = 1'h0, unit_two_match = 1'h0;
  logic [3:0] unit_one_mode = 4'h0, unit_two_mode = 4'h0;
  logic [1:0] port_c_direction = 2'h1, rsp;
  wire logic ext_count_clock_pin, lp_osc_in_pin;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic overflow_irq, unit_one_uses_this, unit_two_uses_this;
  logic [1:0] s_axi_bresp, s_axi_rresp, port_c_direction_eff, port_c_pin_read;
  logic [31:0] s_axi_rdata;
  int err_total = 0;
  int checked = 0;
  row_s rows [5] = '{'{8'h40, 2'h3}, '{8'h48, 2'h3}, '{8'h08, 2'h1}, '{8'h00, 2'h0},
    '{8'hf4, 2'h3}};

  always #20 mclk = ~mclk;

  aux_counter u_aux_counter (.mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_count_clock_pin, .lp_osc_in_pin,
    .lp_osc_enable, .port_c_direction, .unit_one_mode, .unit_one_match, .unit_two_mode,
    .unit_two_match, .overflow_irq, .unit_one_uses_this, .unit_two_uses_this,
    .port_c_direction_eff, .port_c_pin_read);
  ext_clock_src u_ext_clock_src (.pin(ext_count_clock_pin));
  ext_clock_src u_ext_clock_src_osc (.pin(lp_osc_in_pin));

  // ==========
  // bus and compare tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw;
    logic w;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    aw = 1'h0;
    w = 1'h0;
    while (!(aw && w))
    begin
      @(posedge mclk);
      if (!aw && s_axi_awready)
      begin
        aw = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w && s_axi_wready)
      begin
        w = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge mclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    rsp = s_axi_bresp;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge mclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    rd = s_axi_rdata[7:0];
    rsp = s_axi_rresp;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rdr(a);
    chk(16'(rd), 16'(e));
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========
  // watchdog, several times the expected run
  initial
  begin
    #400000;
    err_total++;
    summarize();
  end

  // ==========
  // main sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    arst_n <= 1'h1;
    rchk(ADDR_CONTROL, 8'h00);
    rchk(ADDR_COUNT_HIGH, 8'h00);
    foreach (rows[i])
    begin
      wr(ADDR_CONTROL, rows[i].ctl);
      rchk(ADDR_CONTROL, rows[i].ctl);
      chk(16'({unit_one_uses_this, unit_two_uses_this}), 16'(rows[i].uses));
    end
    wr(8'h14, 8'h55);
    chk(16'(rsp), 16'(RESP_SLVERR));
    rdr(8'h14);
    chk(16'({rd, rsp}), 16'(RESP_SLVERR));
    s_axi_wstrb <= 4'he;
    wr(ADDR_CONTROL, 8'hff);
    s_axi_wstrb <= 4'hf;
    chk(16'(rsp), 16'(RESP_OKAY));
    rchk(ADDR_CONTROL, 8'hf4);
    // only the prescaler phase may add a count
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_COUNT_HIGH, 8'h00);
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_CONTROL, {2'h0, 2'(c), 4'h1});
      repeat (64 << c) @(posedge mclk);
      wr(ADDR_CONTROL, 8'h00);
      rdr(ADDR_COUNT_LOW);
      chk(16'(rd >= 8'h10 && rd <= 8'h12), 16'h1);
      repeat (40) @(posedge mclk);
      rchk(ADDR_COUNT_LOW, rd);
    end
    wr(ADDR_ENABLES, 8'h02);
    wr(ADDR_COUNT_HIGH, 8'hff);
    wr(ADDR_COUNT_LOW, 8'hfd);
    wr(ADDR_CONTROL, 8'h01);
    repeat (40) @(posedge mclk);
    chk(16'(overflow_irq), 16'h1);
    wr(ADDR_CONTROL, 8'h00);
    rchk(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_ENABLES, 8'h00);
    repeat (2) @(posedge mclk);
    chk(16'(overflow_irq), 16'h0);
    rchk(ADDR_FLAGS, 8'h02);
    wr(ADDR_FLAGS, 8'h00);
    rchk(ADDR_FLAGS, 8'h00);
    wr(ADDR_CONTROL, 8'h80);
    wr(ADDR_COUNT_HIGH, 8'h12);
    rchk(ADDR_COUNT_HIGH, 8'h12);
    wr(ADDR_COUNT_LOW, 8'h34);
    wr(ADDR_CONTROL, 8'h00);
    rchk(ADDR_COUNT_HIGH, 8'h12);
    rchk(ADDR_COUNT_LOW, 8'h34);
    wr(ADDR_CONTROL, 8'h80);
    wr(ADDR_COUNT_HIGH, 8'h56);
    rchk(ADDR_COUNT_LOW, 8'h34);
    rchk(ADDR_COUNT_HIGH, 8'h12);
    wr(ADDR_CONTROL, 8'h08);
    unit_one_mode <= SPECIAL_EVENT_MODE;
    unit_two_mode <= 4'ha;
    unit_one_match <= 1'h1;
    unit_two_match <= 1'h1;
    @(posedge mclk);
    unit_one_match <= 1'h0;
    unit_two_match <= 1'h0;
    rchk(ADDR_COUNT_LOW, 8'h34);
    unit_two_mode <= SPECIAL_EVENT_MODE;
    unit_two_match <= 1'h1;
    @(posedge mclk);
    unit_two_match <= 1'h0;
    rchk(ADDR_COUNT_LOW, 8'h00);
    // match pulse lands in the very cycle the low byte write fires
    fork
      wr(ADDR_COUNT_LOW, 8'h77);
      begin
        repeat (2) @(posedge mclk);
        unit_two_match <= 1'h1;
        @(posedge mclk);
        unit_two_match <= 1'h0;
      end
    join
    rchk(ADDR_COUNT_LOW, 8'h77);
    // pin idles low, so the first rise of a burst is never counted
    for (int s = 0; s < 2; s++)
    begin
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_CONTROL, {5'h0, 1'(s), 2'h3});
      u_ext_clock_src.burst(5);
      repeat (10) @(posedge mclk);
      wr(ADDR_CONTROL, 8'h00);
      rchk(ADDR_COUNT_LOW, 8'h04);
    end
    lp_osc_enable <= 1'h1;
    port_c_direction <= 2'h2;
    repeat (3) @(posedge mclk);
    chk(16'({port_c_direction_eff, port_c_pin_read}), 16'hc);
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_CONTROL, 8'h07);
    u_ext_clock_src_osc.burst(3);
    repeat (10) @(posedge mclk);
    wr(ADDR_CONTROL, 8'h00);
    rchk(ADDR_COUNT_LOW, 8'h02);
    lp_osc_enable <= 1'h0;
    repeat (3) @(posedge mclk);
    chk(16'({port_c_direction_eff, port_c_pin_read}), 16'h8);
    // mid-run reset must return control and count to their reset state
    wr(ADDR_CONTROL, 8'h85);
    arst_n <= 1'h0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'h1;
    rchk(ADDR_CONTROL, 8'h00);
    rchk(ADDR_COUNT_LOW, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
